/* acfss_pkg.sv */
// package: constants for the clamp soft-start and mode sequencer
package acfss_pkg;
   // ***********************************************
   // clock and timing
   // ***********************************************
   localparam int CLK_MHZ = 200; // core clock rate
   localparam int FORCED_DCM_US = 706; // forced discontinuous interval, us
   localparam int FORCED_DCM_CYC = FORCED_DCM_US * CLK_MHZ; // cycles in that interval
   localparam int MIN_CLAMP_NS = 250; // shortest clamp pulse, ns
   localparam int MIN_CLAMP_CYC = (MIN_CLAMP_NS * CLK_MHZ + 999) / 1000; // rounded up
   localparam int SETTLE_MULT = 2; // settle interval in soft-start times
   localparam int SS_STEP_CYC = 64; // cycles per current-limit ramp step
   localparam int ILIM_W = 10; // current-limit reference width
   localparam logic [ILIM_W-1:0] ILIM_MAX = 10'h3ff; // final current-limit code
   localparam int SS_CYC = (1 << ILIM_W) * SS_STEP_CYC; // full ramp length
   localparam int SETTLE_CYC = SETTLE_MULT * SS_CYC; // settle length
   localparam int CNT_W = 24; // timer width
   // ***********************************************
   // bins, references and slope
   // ***********************************************
   localparam int BIN_W = 4; // bin code width
   localparam int REF_W = 12; // reference code width, mV
   localparam int NBINS = 15; // number of bins
   localparam logic [REF_W-1:0] REF_LO_MV = 12'h410; // 1.04 V, lowest bin
   localparam logic [REF_W-1:0] REF_STEP_MV = 12'h0a0; // 0.16 V per bin up to 3.28 V
   localparam logic [REF_W-1:0] SLOPE_MV_PER_US = 12'h08f; // 143 mV/us
   localparam int SLOPE_ACC_W = 20; // slope accumulator width
   localparam logic [SLOPE_ACC_W-1:0] SLOPE_MV_PER_CYC_X1K = 20'h002cb; // 715 = 143*5
   localparam int PER_W = 12; // switching period count width
   localparam logic [PER_W-1:0] PER_DEFAULT = 12'h3e8; // default period: 200 kHz
   // ***********************************************
   // sequencer states
   // ***********************************************
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001, // waiting for start criteria
      ST_FDCM = 6'b000010, // forced discontinuous switching
      ST_LEM = 6'b000100, // clamp pulses phased in
      ST_SETTLE = 6'b001000, // clamped, detection frozen
      ST_ACF = 6'b010000, // clamped, free to follow load
      ST_DCM = 6'b100000 // discontinuous after soft stop
   } acfss_state_e;
endpackage : acfss_pkg

/* acfss_pwm.sv */
// file: switching-period generator producing main and clamp drive pulses
`timescale 1ns/1ps
module acfss_pwm (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_run, // switching allowed
   input wire logic [acfss_pkg::PER_W-1:0] i_period, // switching period in cycles
   input wire logic [acfss_pkg::PER_W-1:0] i_clamp_len, // clamp pulse length, 0 = none
   input wire logic i_cmp_trip, // peak-current comparator trip
   output logic o_main, // main switch pulse
   output logic o_clamp, // clamp pulse
   output logic o_cycle_start // pulse at start of each period
);
   import acfss_pkg::*;
   logic [PER_W-1:0] cnt_q; // position within the period
   logic main_q; // main pulse state
   logic clamp_q; // clamp pulse state
   logic start_q; // period start strobe
   wire period_end = (cnt_q >= i_period - 12'h001); // last cycle of the period
   // leading edge of clamp; one cycle earlier so the pulse spans exactly i_clamp_len clocks
   // while still ending on the same edge at which the main pulse restarts
   wire [PER_W-1:0] clamp_from = i_period - i_clamp_len - 12'h001;
   wire clamp_win = (i_clamp_len != 12'h000) && (cnt_q >= clamp_from) && !period_end;
   // ***********************************************
   // period counter and pulses
   // ***********************************************
   always_ff @(posedge i_clk) begin
      if (i_srst || !i_run) begin // stopped: both drives low
         cnt_q <= 12'h000;
         main_q <= 1'b0;
         clamp_q <= 1'b0;
         start_q <= 1'b0;
      end else begin
         cnt_q <= period_end ? 12'h000 : cnt_q + 12'h001;
         start_q <= period_end;
         main_q <= period_end ? 1'b1 : (main_q && !i_cmp_trip); // on at start, off at trip
         clamp_q <= clamp_win && !main_q; // clamp only after main is off
      end
   end
   assign o_main = main_q;
   assign o_clamp = clamp_q;
   assign o_cycle_start = start_q;
endmodule : acfss_pwm

/* acfss_sequencer.sv */
// file: clamp soft-start and mode sequencer top
// Behaviour
// RL1: bin selects fixed internal reference only
// RL2: fifteen references 1.04 V to 3.28 V
// RL3: exit pin observed after soft start, settle
// RL4: exit source on above turn-on, off DISCONTINUOUS_MODE
// RL5: soft start needs supply, line, nofault, delay
// RL6: forced discontinuous 706 us before clamp pulses
// RL7: ignore high feedback during forced interval
// RL8: ramp current-limit reference through soft start
// RL9: clamp pulses grow by leading-edge modulation
// RL10: full clamped mode at maximum current limit
// RL11: hold mode detection twice soft-start time
// RL12: ramp frequency to half oscillator rate
// RL13: fixed 143 mV/us slope compensation
// RL14: clamp drive is logic-level square wave
// RL15: clamp pulse grows from 250 ns
// RL16: feedback above reference requests clamped mode
// RL17: exit after feedback held below threshold
// RL18: fault or reset returns to idle
// RL19: counters time forced and settle intervals
`timescale 1ns/1ps
module acfss_sequencer #(
   parameter int FORCED_CYC = acfss_pkg::FORCED_DCM_CYC, // forced interval length
   parameter int SETTLE_LEN = acfss_pkg::SETTLE_CYC, // settle interval length
   parameter int EXIT_HOLD_CYC = 100000 // exit hold time
) (
   input wire logic i_clk,
   input wire logic i_srst, // supply under-voltage reset
   input wire logic i_vcc_on, // supply above turn-on (pin)
   input wire logic i_line_ok, // line above line_start_level (pin)
   input wire logic i_fault, // any fault (pin)
   input wire logic i_start_dly_done, // start delay elapsed (pin)
   input wire logic [acfss_pkg::BIN_W-1:0] i_entry_bin, // quantised clamp_entry_threshold_pin
   input wire logic [acfss_pkg::REF_W-1:0] i_feedback_mv, // feedback_voltage, mV
   input wire logic i_exit_below, // feedback below clamp_exit_threshold_pin (pin)
   input wire logic i_cs_trip, // peak current comparator (pin)
   input wire logic [acfss_pkg::PER_W-1:0] i_osc_period, // period set by resistor
   output logic o_main_gate_drive, // main switch drive
   output logic o_clamp_gate_drive, // clamp drive, 5 V logic
   output logic o_exit_src_en, // 16 uA exit pin source enable
   output logic o_exit_observe, // exit pin comparator observed
   output logic [acfss_pkg::ILIM_W-1:0] o_ilim_ref, // current-limit reference
   output logic [acfss_pkg::REF_W-1:0] o_entry_ref_mv, // selected entry reference
   output logic [acfss_pkg::SLOPE_ACC_W-1:0] o_slope_ramp, // slope comp ramp, uV
   output logic [5:0] o_state // sequencer state
);
   import acfss_pkg::*;
   // ***********************************************
   // functions
   // ***********************************************
   // saturating increment toward a limit
   function automatic logic [PER_W-1:0] step_to(input logic [PER_W-1:0] v,
                                                input logic [PER_W-1:0] lim);
      step_to = (v < lim) ? v + 12'h001 : lim;
   endfunction : step_to
   // ***********************************************
   // input synchronisers
   // ***********************************************
   logic [5:0] meta_q; // first stage
   logic [5:0] sync_q; // second stage
   logic [BIN_W-1:0] bin_meta_q; // bin first stage
   logic [BIN_W-1:0] bin_q; // bin second stage
   logic [REF_W-1:0] fb_meta_q; // feedback first stage
   logic [REF_W-1:0] fb_q; // feedback second stage
   logic [PER_W-1:0] osc_meta_q; // oscillator period first stage
   logic [PER_W-1:0] osc_q; // oscillator period second stage, static in use
   always_ff @(posedge i_clk) begin
      meta_q <= {i_vcc_on, i_line_ok, i_fault, i_start_dly_done, i_exit_below, i_cs_trip};
      sync_q <= meta_q;
      bin_meta_q <= i_entry_bin;
      bin_q <= bin_meta_q;
      fb_meta_q <= i_feedback_mv;
      fb_q <= fb_meta_q;
      osc_meta_q <= i_osc_period;
      osc_q <= osc_meta_q;
   end
   wire vcc_on = sync_q[5];
   wire line_ok = sync_q[4];
   wire fault = sync_q[3];
   wire dly_done = sync_q[2];
   wire exit_below = sync_q[1];
   wire cs_trip = sync_q[0];
   // ***********************************************
   // entry reference selection
   // ***********************************************
   // bin maps to a fixed tap; codes above the top bin clamp to it
   wire [BIN_W-1:0] bin_c = (bin_q > 4'(NBINS - 1)) ? 4'(NBINS - 1) : bin_q; // RL2
   wire [REF_W-1:0] entry_ref = REF_LO_MV + REF_STEP_MV * {8'h00, bin_c}; // RL1 RL2
   wire entry_req = (fb_q > entry_ref); // RL16
   // ***********************************************
   // state and timers
   // ***********************************************
   acfss_state_e state_q, state_d; // sequencer state
   logic [CNT_W-1:0] tmr_q; // interval timer
   logic [CNT_W-1:0] hold_q; // exit hold timer
   logic [ILIM_W-1:0] ilim_q; // current-limit reference
   logic [7:0] ss_div_q; // ramp step divider
   logic [PER_W-1:0] per_q; // working period
   logic [PER_W-1:0] clamp_len_q; // working clamp pulse length
   logic src_en_q; // exit source enable
   logic observe_q; // exit pin observed
   logic [SLOPE_ACC_W-1:0] slope_q; // slope ramp accumulator
   wire start_ok = vcc_on && line_ok && !fault && dly_done; // RL5
   wire forced_done = (tmr_q >= CNT_W'(FORCED_CYC - 1)); // RL6 RL19
   wire settle_done = (tmr_q >= CNT_W'(SETTLE_LEN - 1)); // RL11 RL19
   wire hold_done = (hold_q >= CNT_W'(EXIT_HOLD_CYC - 1)); // RL17
   wire ss_tick = (ss_div_q == 8'(SS_STEP_CYC - 1)); // ramp step strobe
   wire ilim_full = (ilim_q == ILIM_MAX); // RL10
   wire [PER_W-1:0] half_rate_per = {osc_q[PER_W-2:0], 1'b0}; // half frequency
   wire [PER_W-1:0] clamp_full = per_q >> 1; // off-time fraction available
   wire pwm_run = (state_q != ST_IDLE);
   wire cycle_start;
   wire pwm_main;
   wire pwm_clamp;
   // next-state decoding
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: if (start_ok) state_d = ST_FDCM; // RL5
         ST_FDCM: if (forced_done) state_d = ST_LEM; // RL6 RL7
         ST_LEM: if (ilim_full && clamp_len_q >= clamp_full) state_d = ST_SETTLE; // RL10
         ST_SETTLE: if (settle_done) state_d = ST_ACF; // RL11
         ST_ACF: if (hold_done) state_d = ST_DCM; // RL17
         ST_DCM: if (entry_req) state_d = ST_LEM; // RL16
         default: state_d = ST_IDLE;
      endcase
      if (fault || !vcc_on) state_d = ST_IDLE; // RL18
   end
   // state register and interval timer
   always_ff @(posedge i_clk) begin
      if (i_srst) begin // RL18
         state_q <= ST_IDLE;
         tmr_q <= '0;
      end else begin
         state_q <= state_d;
         tmr_q <= (state_d != state_q) ? '0 : tmr_q + 24'h000001; // RL19
      end
   end
   // exit hold timer: runs while feedback below exit level in ST_ACF
   always_ff @(posedge i_clk) begin
      if (i_srst || state_q != ST_ACF || !exit_below) begin
         hold_q <= '0;
      end else begin
         hold_q <= hold_q + 24'h000001; // RL17
      end
   end
   // current-limit ramp during soft start
   always_ff @(posedge i_clk) begin
      if (i_srst || state_q == ST_IDLE) begin
         ilim_q <= '0;
         ss_div_q <= 8'h00;
      end else begin
         ss_div_q <= ss_tick ? 8'h00 : ss_div_q + 8'h01;
         if (ss_tick && !ilim_full) begin
            ilim_q <= ilim_q + 10'h001; // RL8
         end
      end
   end
   // frequency ramp and clamp pulse growth
   always_ff @(posedge i_clk) begin
      if (i_srst || state_q == ST_IDLE) begin
         per_q <= 12'hfff; // start slow
         clamp_len_q <= 12'h000;
      end else if (cycle_start) begin
         if (state_q == ST_FDCM || state_q == ST_DCM) begin
            // period walks toward the half-rate value
            per_q <= (per_q > half_rate_per) ? per_q - 12'h001 : half_rate_per; // RL12
            clamp_len_q <= 12'h000; // RL6
         end else if (state_q == ST_LEM) begin
            per_q <= osc_q;
            // first pulse at minimum, then one cycle longer each period
            clamp_len_q <= (clamp_len_q < 12'(MIN_CLAMP_CYC)) ?
                           12'(MIN_CLAMP_CYC) : step_to(clamp_len_q, clamp_full); // RL9 RL15
         end else begin
            per_q <= osc_q;
            clamp_len_q <= clamp_full;
         end
      end
   end
   // exit pin source and observation
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         src_en_q <= 1'b0;
         observe_q <= 1'b0;
      end else begin
         src_en_q <= vcc_on && (state_d != ST_DCM) && (state_d != ST_FDCM); // RL4
         observe_q <= (state_d == ST_ACF); // RL3
      end
   end
   // slope compensation ramp, reset each period
   always_ff @(posedge i_clk) begin
      if (i_srst || cycle_start || !pwm_main) begin
         slope_q <= '0;
      end else begin
         slope_q <= slope_q + SLOPE_MV_PER_CYC_X1K; // RL13
      end
   end
   // ***********************************************
   // pulse generator
   // ***********************************************
   acfss_pwm u_pwm (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_run(pwm_run),
      .i_period(per_q),
      .i_clamp_len(clamp_len_q),
      .i_cmp_trip(cs_trip),
      .o_main(pwm_main),
      .o_clamp(pwm_clamp),
      .o_cycle_start(cycle_start)
   );
   // ***********************************************
   // registered outputs
   // ***********************************************
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_main_gate_drive <= 1'b0;
         o_clamp_gate_drive <= 1'b0;
         o_exit_src_en <= 1'b0;
         o_exit_observe <= 1'b0;
         o_ilim_ref <= '0;
         o_entry_ref_mv <= '0;
         o_slope_ramp <= '0;
         o_state <= ST_IDLE;
      end else begin
         o_main_gate_drive <= pwm_main && pwm_run && !fault; // RL18
         o_clamp_gate_drive <= pwm_clamp && pwm_run && !fault; // RL14
         o_exit_src_en <= src_en_q;
         o_exit_observe <= observe_q;
         o_ilim_ref <= ilim_q;
         o_entry_ref_mv <= entry_ref;
         o_slope_ramp <= slope_q;
         o_state <= state_q;
      end
   end
endmodule : acfss_sequencer

/* acfss_sequencer_properties.sv */
// checker: concurrent properties on the sequencer top ports
`timescale 1ns/1ps
module acfss_sequencer_chk
   import acfss_pkg::*;
#(
   parameter int FORCED_CYC = 200, // forced interval length
   parameter int SETTLE_LEN = 300 // settle interval length
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_fault,
   input wire logic [acfss_pkg::BIN_W-1:0] i_entry_bin,
   input wire logic o_main_gate_drive,
   input wire logic o_clamp_gate_drive,
   input wire logic o_exit_src_en,
   input wire logic o_exit_observe,
   input wire logic [acfss_pkg::ILIM_W-1:0] o_ilim_ref,
   input wire logic [acfss_pkg::REF_W-1:0] o_entry_ref_mv,
   input wire logic [5:0] o_state
);
   // ***********************************************
   // dwell counter
   // ***********************************************
   logic [5:0] prev_q; // state one edge earlier
   logic [23:0] dwell_q; // edges spent in the present state
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);
   // restart the count on every state change
   always_ff @(posedge i_clk) begin
      prev_q <= o_state;
      if (i_srst || o_state != prev_q) begin
         dwell_q <= 24'h000001;
      end else begin
         dwell_q <= dwell_q + 24'h000001;
      end
   end
   // ***********************************************
   // properties
   // ***********************************************
   AST_START_BLOCKED: assert property (i_fault[*4] ##0 o_state == ST_IDLE |=> o_state == ST_IDLE)
      else $error("left idle while fault present");
   AST_FDCM_NO_CLAMP: assert property (o_state == ST_FDCM |-> !o_clamp_gate_drive)
      else $error("clamp pulse in forced interval");
   AST_FDCM_LEN: assert property (o_state == ST_LEM && prev_q == ST_FDCM |->
      dwell_q >= FORCED_CYC - 1 && dwell_q <= FORCED_CYC + 2)
      else $error("forced interval length wrong");
   AST_SETTLE_LEN: assert property (o_state == ST_ACF && prev_q == ST_SETTLE |->
      dwell_q >= SETTLE_LEN - 1 && dwell_q <= SETTLE_LEN + 2)
      else $error("settle interval length wrong");
   AST_ILIM_FULL: assert property (o_state == ST_SETTLE && prev_q == ST_LEM |-> o_ilim_ref == ILIM_MAX)
      else $error("clamped mode before full current limit");
   AST_ILIM_RAMP: assert property (o_state == prev_q && (o_state == ST_FDCM || o_state == ST_LEM)
      |-> o_ilim_ref >= $past(o_ilim_ref))
      else $error("current limit ramp fell");
   AST_SRC_OFF: assert property (o_state == ST_FDCM || o_state == ST_DCM |-> !o_exit_src_en)
      else $error("exit source on in discontinuous mode");
   AST_OBSERVE: assert property (o_exit_observe |-> o_state == ST_ACF)
      else $error("exit pin observed outside free clamped state");
   AST_FAULT_STOP: assert property (i_fault[*5] |->
      o_state == ST_IDLE && !o_main_gate_drive && !o_clamp_gate_drive)
      else $error("fault did not stop drives");
   AST_NO_OVERLAP: assert property (!(o_main_gate_drive && o_clamp_gate_drive))
      else $error("main and clamp drive overlap");
   AST_ENTRY_REF: assert property (($stable(i_entry_bin) && i_entry_bin < 4'hf)[*6] |->
      o_entry_ref_mv == REF_LO_MV + REF_STEP_MV * REF_W'(i_entry_bin))
      else $error("entry reference wrong for bin");
   // main sequence milestones
   COV_LEM: cover property (o_state == ST_LEM && prev_q == ST_FDCM);
   COV_ACF: cover property (o_state == ST_ACF && prev_q == ST_SETTLE);
   COV_DCM: cover property (o_state == ST_DCM && prev_q == ST_ACF);
   COV_REENTRY: cover property (o_state == ST_LEM && prev_q == ST_DCM);
endmodule : acfss_sequencer_chk
bind acfss_sequencer acfss_sequencer_chk #(.FORCED_CYC(FORCED_CYC), .SETTLE_LEN(SETTLE_LEN)) chk_u (
   .i_clk, .i_srst, .i_fault, .i_entry_bin, .o_main_gate_drive, .o_clamp_gate_drive,
   .o_exit_src_en, .o_exit_observe, .o_ilim_ref, .o_entry_ref_mv, .o_state);

/* acfss_switch_model.sv */
// partner: main switch current sense stand-in
`timescale 1ns/1ps
module acfss_switch_model #(
   parameter int FAST_CYC = 20, // cycles to peak current, light load
   parameter int SLOW_CYC = 60 // cycles to peak current, heavy load
) (
   input wire logic i_clk,
   input wire logic i_main, // main switch gate
   input wire logic i_slow, // pick the slower current rise
   output logic o_cs_trip // peak current comparator
);
   int on_cnt = 0; // cycles the switch has conducted
   // current rises only while the switch conducts
   always @(posedge i_clk) begin
      on_cnt <= i_main ? on_cnt + 1 : 0;
   end
   // trip low whenever the switch is off, no stale level
   assign o_cs_trip = i_main && (on_cnt >= (i_slow ? SLOW_CYC : FAST_CYC));
endmodule : acfss_switch_model

/* acfss_sequencer_tb.sv */
// testbench: start-up, mode and reference scenarios for the sequencer
`timescale 1ns/1ps
module acfss_sequencer_tb;
   import acfss_pkg::*;
   localparam int FC = 200; // shortened forced interval
   localparam int SL = 300; // shortened settle interval
   localparam int EH = 50; // shortened exit hold
   logic i_clk, i_srst, i_vcc_on, i_line_ok, i_fault, i_start_dly_done, i_exit_below, i_cs_trip;
   logic slow; // partner current rise choice
   logic [BIN_W-1:0] i_entry_bin;
   logic [REF_W-1:0] i_feedback_mv;
   logic [PER_W-1:0] i_osc_period;
   logic o_main_gate_drive, o_clamp_gate_drive, o_exit_src_en, o_exit_observe;
   logic [ILIM_W-1:0] o_ilim_ref;
   logic [REF_W-1:0] o_entry_ref_mv;
   logic [SLOPE_ACC_W-1:0] o_slope_ramp;
   logic [5:0] o_state;
   int fail_count = 0;
   int num_checks = 0;
   acfss_sequencer #(.FORCED_CYC(FC), .SETTLE_LEN(SL), .EXIT_HOLD_CYC(EH)) dut_u (
      .i_clk, .i_srst, .i_vcc_on, .i_line_ok, .i_fault, .i_start_dly_done, .i_entry_bin,
      .i_feedback_mv, .i_exit_below, .i_cs_trip, .i_osc_period, .o_main_gate_drive,
      .o_clamp_gate_drive, .o_exit_src_en, .o_exit_observe, .o_ilim_ref, .o_entry_ref_mv,
      .o_slope_ramp, .o_state);
   acfss_switch_model sw_u (.i_clk, .i_main(o_main_gate_drive), .i_slow(slow), .o_cs_trip(i_cs_trip));
   // ***********************************************
   // shared tasks
   // ***********************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s seen %0h exp %0h", $time, what, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   // bounded wait for a state, n gives edges taken
   task automatic wait_state(input logic [5:0] s, input int lim, output int n);
      n = 0;
      while (o_state !== s) begin
         @(negedge i_clk);
         n++;
         if (n > lim) begin
            check(o_state, s, "state wait expired");
            final_report();
         end
      end
   endtask : wait_state
   // width of the next clamp pulse
   task automatic clamp_w(output int w);
      int n;
      n = 0;
      w = 0;
      while (o_clamp_gate_drive !== 1'b1 && n < 5000) begin
         @(negedge i_clk);
         n++;
      end
      while (o_clamp_gate_drive === 1'b1 && w < 5000) begin
         @(negedge i_clk);
         w++;
      end
      if (n >= 5000 || w >= 5000) begin
         check(1'b0, 1'b1, "clamp pulse wait expired");
         final_report();
      end
   endtask : clamp_w
   // clocks from one main drive rising edge to the next
   task automatic main_per(output int p);
      int n;
      n = 0;
      p = 0;
      while (o_main_gate_drive !== 1'b0 && n < 5000) begin
         @(negedge i_clk);
         n++;
      end
      while (o_main_gate_drive !== 1'b1 && n < 5000) begin
         @(negedge i_clk);
         n++;
      end
      while (o_main_gate_drive === 1'b1 && n + p < 5000) begin
         @(negedge i_clk);
         p++;
      end
      while (o_main_gate_drive !== 1'b1 && n + p < 5000) begin
         @(negedge i_clk);
         p++;
      end
      if (n + p >= 5000) begin
         check(1'b0, 1'b1, "main pulse wait expired");
         final_report();
      end
   endtask : main_per
   // ***********************************************
   // scenarios
   // ***********************************************
   task automatic t_refs();
      for (int b = 0; b < 16; b++) begin
         i_entry_bin = b[3:0];
         repeat (6) @(negedge i_clk);
         check(o_entry_ref_mv, 32'h410 + 32'ha0 * ((b > 14) ? 14 : b), "entry ref");
      end
   endtask : t_refs
   task automatic t_gate();
      logic [3:0] ok;
      for (int m = 0; m < 4; m++) begin
         ok = 4'hf ^ (4'h1 << m);
         {i_vcc_on, i_line_ok, i_start_dly_done} = ok[3:1];
         i_fault = !ok[0];
         repeat (12) @(negedge i_clk);
         check(o_state, ST_IDLE, "started without all criteria");
      end
   endtask : t_gate
   task automatic t_fault();
      int n;
      {i_vcc_on, i_line_ok, i_start_dly_done, i_fault} = 4'he;
      i_feedback_mv = 12'hfff;
      slow = 1'b1;
      wait_state(ST_FDCM, 20, n);
      repeat (20) @(negedge i_clk);
      check(o_state, ST_FDCM, "high feedback left forced interval");
      check(o_exit_src_en, 1'b0, "exit source on in forced interval");
      i_fault = 1'b1;
      repeat (5) @(negedge i_clk);
      check({o_state, o_main_gate_drive, o_clamp_gate_drive}, {ST_IDLE, 2'b00}, "fault");
      i_fault = 1'b0;
   endtask : t_fault
   task automatic t_soft();
      int n;
      int w1;
      int w2;
      slow = 1'b0;
      wait_state(ST_FDCM, 20, n);
      wait_state(ST_LEM, FC + 50, n);
      check(n >= FC - 1 && n <= FC + 2, 1'b1, "forced interval length");
      clamp_w(w1);
      clamp_w(w2);
      check(w1 >= MIN_CLAMP_CYC && w1 <= MIN_CLAMP_CYC + 1, 1'b1, "first clamp width");
      check(w2 > w1, 1'b1, "clamp pulse not growing");
      wait_state(ST_SETTLE, 80000, n);
      check(o_ilim_ref, ILIM_MAX, "limit not full at clamped entry");
      wait_state(ST_ACF, SL + 50, n);
      check(n >= SL - 1 && n <= SL + 2, 1'b1, "settle length");
      repeat (2) @(negedge i_clk);
      check({o_exit_observe, o_exit_src_en}, 2'b11, "exit pin not watched");
   endtask : t_soft
   task automatic t_exit();
      int n;
      int p;
      int sa;
      int sb;
      i_feedback_mv = 12'h000;
      i_exit_below = 1'b1;
      wait_state(ST_DCM, EH + 50, n);
      check(n >= EH && n <= EH + 8, 1'b1, "exit hold time");
      repeat (2) @(negedge i_clk);
      check({o_exit_observe, o_exit_src_en}, 2'b00, "exit source in discontinuous");
      i_exit_below = 1'b0;
      i_entry_bin = 4'h0;
      i_feedback_mv = 12'h3e8;
      repeat (20) @(negedge i_clk);
      check(o_state, ST_DCM, "entered clamp below reference");
      main_per(p);
      main_per(p);
      check(p, 2 * i_osc_period, "discontinuous period not half rate");
      repeat (3) @(negedge i_clk);
      sa = o_slope_ramp;
      @(negedge i_clk);
      sb = o_slope_ramp;
      check(sb - sa, 143 * 1000 / CLK_MHZ, "slope step per clock");
      i_feedback_mv = 12'h44c;
      wait_state(ST_LEM, 20, n);
   endtask : t_exit
   // ***********************************************
   // clock and main sequence
   // ***********************************************
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   initial begin
      i_srst = 1'b1;
      {i_vcc_on, i_line_ok, i_fault, i_start_dly_done, i_exit_below, slow} = 6'h00;
      i_entry_bin = 4'h0;
      i_feedback_mv = 12'h000;
      i_osc_period = 12'h0c8;
      repeat (5) @(negedge i_clk);
      i_srst = 1'b0;
      t_refs();
      t_gate();
      t_fault();
      t_soft();
      t_exit();
      final_report();
   end
endmodule : acfss_sequencer_tb
